// [logic/qas_top.sv]
// quinary pad address selection and bus address match for a serial LED driver
//
// Function
// - address built only from three pads, pad 2 most significant
// - each pad resolves to one of five connection states
// - pads sampled and address latched at power-up and every reset
// - pad sensing switched off once address latched, until next reset
// - three pads select among 125 distinct addresses
// - address equals 25*msd + 5*mid + lsd + 1
// - output enable low lets LEDs run, high blanks them
// - reset pin low resets device and resamples pads
// - bus soft-reset call reinitialises like power-on, LEDs off
`timescale 1ns/1ps
module qas_top
   import qas_pkg::*;
(
   // core clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   // address pads, resolved codes
   input  wire logic [PAD_W-1:0]    addr_pad_lsd,
   input  wire logic [PAD_W-1:0]    addr_pad_mid,
   input  wire logic [PAD_W-1:0]    addr_pad_msd,
   // output enable pin, active low
   input  wire logic                oe_n,
   // two-wire bus link
   input  wire logic                scl_i,
   input  wire logic                sda_i,
   output      logic                sda_o,
   output      logic                sda_oe,
   // core side status
   output      logic                pad_sense_en,
   output      logic [ADDR_W-1:0]   target_addr,
   output      logic                addr_valid,
   output      logic                led_out_en,
   output      logic                addr_hit,
   output      logic                soft_reset
);

   // ****************************************************************
   // address arithmetic
   // ****************************************************************
   // weighted sum of the three quinary digits
   function automatic logic [ADDR_W-1:0] pad_to_addr(input logic [PAD_W-1:0] msd, mid, lsd);
      logic [13:0] sum;
      sum = 14'(msd) * 14'(WEIGHT_MSD) + 14'(mid) * 14'(WEIGHT_MID) + 14'(lsd) + 14'(ADDR_OFFSET);
      return sum[ADDR_W-1:0];
   endfunction : pad_to_addr
   // a code above supply is not a pad state
   function automatic logic pad_ok(input logic [PAD_W-1:0] code);
      return code <= PAD_SUPPLY;
   endfunction : pad_ok

   // ****************************************************************
   // pin synchronisers, core domain
   // ****************************************************************
   logic [PADS_W-1:0] pads_s;
   logic              oe_n_s;
   logic [1:0]        tgl_s;
   logic              hit_tgl_q;
   logic              swr_tgl_q;
   qas_sync #(.W(PADS_W), .RST('0)) u_pad_sync
   (
      .clk     (core_clk),
      .rst_n   (rst_n),
      .d_async ({addr_pad_msd, addr_pad_mid, addr_pad_lsd}),
      .q_sync  (pads_s)
   );
   qas_sync #(.W(1), .RST(1'b1)) u_oe_sync
   (
      .clk     (core_clk),
      .rst_n   (rst_n),
      .d_async (oe_n),
      .q_sync  (oe_n_s)
   );
   // event toggles from the link domain
   qas_sync #(.W(2), .RST(2'h0)) u_tgl_sync
   (
      .clk     (core_clk),
      .rst_n   (rst_n),
      .d_async ({swr_tgl_q, hit_tgl_q}),
      .q_sync  (tgl_s)
   );

   // ****************************************************************
   // core sequencing
   // ****************************************************************
   qas_core_st_t          core_st_q;
   logic [SETTLE_W-1:0]   settle_q;
   logic [1:0]            tgl_last_q;
   logic                  swr_evt;
   logic                  hit_evt;
   logic [PAD_W-1:0]      p_msd;
   logic [PAD_W-1:0]      p_mid;
   logic [PAD_W-1:0]      p_lsd;
   logic                  pads_good;
   assign p_msd     = pads_s[3*PAD_W-1:2*PAD_W];
   assign p_mid     = pads_s[2*PAD_W-1:PAD_W];
   assign p_lsd     = pads_s[PAD_W-1:0];
   assign pads_good = pad_ok(p_msd) && pad_ok(p_mid) && pad_ok(p_lsd);
   assign swr_evt   = tgl_s[1] != tgl_last_q[1];
   assign hit_evt   = tgl_s[0] != tgl_last_q[0];
   // edge memory for the crossed toggles
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         tgl_last_q <= 2'h0;
      else
         tgl_last_q <= tgl_s;
   end
   // sense after reset, pin reset restarts here, soft call too
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         core_st_q <= QAS_SENSE;
         settle_q  <= '0;
      end
      else if (swr_evt)
      begin
         core_st_q <= QAS_SENSE;
         settle_q  <= '0;
      end
      else
      begin
         unique case (core_st_q)
            QAS_SENSE:
            begin
               // settle time lets the pad sensors and synchronisers fill
               if (settle_q == SETTLE_W'(PAD_SETTLE_CYC))
                  core_st_q <= QAS_RUN;
               else
                  settle_q <= settle_q + SETTLE_W'(1);
            end
            QAS_RUN:
               core_st_q <= QAS_RUN;
         endcase
      end
   end
   // sensing powered only while the address is still open
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         pad_sense_en <= 1'b1;
      else
         pad_sense_en <= swr_evt || (core_st_q == QAS_SENSE && settle_q != SETTLE_W'(PAD_SETTLE_CYC));
   end
   // latch the pad sum at the end of sensing
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         target_addr <= ADDR_RESET;
         addr_valid  <= 1'b0;
      end
      else if (swr_evt)
      begin
         target_addr <= ADDR_RESET;
         addr_valid  <= 1'b0;
      end
      else if (core_st_q == QAS_SENSE && settle_q == SETTLE_W'(PAD_SETTLE_CYC))
      begin
         target_addr <= pad_to_addr(p_msd, p_mid, p_lsd);
         // an illegal code leaves the device deaf to its own address; general call is still acknowledged
         addr_valid  <= pads_good;
      end
   end
   // LEDs blank while the pin is high or a reset is running
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         led_out_en <= 1'b0;
      else
         led_out_en <= !oe_n_s && core_st_q == QAS_RUN && !swr_evt;
   end
   // one-cycle pulses for the rest of the chip
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         soft_reset <= 1'b0;
         addr_hit   <= 1'b0;
      end
      else
      begin
         soft_reset <= swr_evt;
         addr_hit   <= hit_evt && !swr_evt;
      end
   end

   // ****************************************************************
   // link domain: start detection, address shift, acknowledge
   // ****************************************************************
   qas_link_st_t        link_st_q;
   logic                start_tgl_q;
   logic                start_seen_q;
   logic [3:0]          bit_cnt_q;
   logic [BYTE_W-1:0]   shift_q;
   logic                vld_s;
   logic                own_match;
   logic                gc_write;
   logic                swr_byte;
   // START is SDA falling with SCL high; SDA only clocks this toggle
   always_ff @(negedge sda_i or negedge rst_n)
   begin
      if (!rst_n)
         start_tgl_q <= 1'b0;
      else if (scl_i)
         start_tgl_q <= !start_tgl_q;
   end
   // address is quasi-static, gated by a valid that needs four link edges to cross
   qas_sync #(.W(1), .RST(1'b0)) u_vld_sync
   (
      .clk     (scl_i),
      .rst_n   (rst_n),
      .d_async (addr_valid),
      .q_sync  (vld_s)
   );
   assign own_match = vld_s && shift_q[BYTE_W-1:1] == target_addr && !shift_q[0];
   assign gc_write  = shift_q == {GEN_CALL_ADDR, 1'b0};
   assign swr_byte  = shift_q == SOFT_RST_BYTE;
   // first byte after START is the target address
   always_ff @(posedge scl_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link_st_q    <= QAS_L_IDLE;
         start_seen_q <= 1'b0;
         bit_cnt_q    <= BIT_CNT_ZERO;
         shift_q      <= '0;
         hit_tgl_q    <= 1'b0;
         swr_tgl_q    <= 1'b0;
      end
      else if (start_tgl_q != start_seen_q)
      begin
         start_seen_q <= start_tgl_q;
         link_st_q    <= QAS_L_ADDR;
         bit_cnt_q    <= BIT_CNT_ONE;
         shift_q      <= {{(BYTE_W-1){1'b0}}, sda_i};
      end
      else
      begin
         unique case (link_st_q)
            QAS_L_IDLE, QAS_L_SKIP:
               link_st_q <= link_st_q;
            QAS_L_ADDR, QAS_L_DATA:
            begin
               if (bit_cnt_q != BITS_PER_BYTE)
               begin
                  shift_q   <= {shift_q[BYTE_W-2:0], sda_i};
                  bit_cnt_q <= bit_cnt_q + BIT_CNT_ONE;
               end
               else if (link_st_q == QAS_L_ADDR && own_match)
               begin
                  // register traffic after this is handled elsewhere
                  hit_tgl_q <= !hit_tgl_q;
                  link_st_q <= QAS_L_SKIP;
               end
               else if (link_st_q == QAS_L_ADDR && gc_write)
               begin
                  link_st_q <= QAS_L_DATA;
                  bit_cnt_q <= BIT_CNT_ZERO;
               end
               else
               begin
                  // soft-reset byte of a general call
                  if (link_st_q == QAS_L_DATA && swr_byte)
                     swr_tgl_q <= !swr_tgl_q;
                  link_st_q <= QAS_L_SKIP;
               end
            end
         endcase
      end
   end
   // acknowledge slot: drive low after the eighth bit, release one clock later
   always_ff @(negedge scl_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sda_oe <= 1'b0;
         sda_o  <= 1'b0;
      end
      else
      begin
         sda_o  <= 1'b0;
         sda_oe <= bit_cnt_q == BITS_PER_BYTE &&
                   ((link_st_q == QAS_L_ADDR && (own_match || gc_write)) ||
                    (link_st_q == QAS_L_DATA && swr_byte));
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   a_addr_formula: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (core_st_q == QAS_SENSE && settle_q == SETTLE_W'(PAD_SETTLE_CYC) && !swr_evt)
      |=> target_addr == pad_to_addr($past(p_msd), $past(p_mid), $past(p_lsd)))
      else $error("latched address differs from pad sum");
   a_addr_range: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      addr_valid |-> (target_addr >= 7'h01 && target_addr <= 7'h7D))
      else $error("valid address outside the 125 slots");
   a_invalid_pad: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (core_st_q == QAS_SENSE && settle_q == SETTLE_W'(PAD_SETTLE_CYC) && !pads_good && !swr_evt)
      |=> !addr_valid)
      else $error("illegal pad code produced a valid address");
   a_sense_off: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (core_st_q == QAS_RUN && !swr_evt) |=> !pad_sense_en)
      else $error("pad sensing left on after latch");
   a_sense_window: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(soft_reset) |-> pad_sense_en && !addr_valid ##1 pad_sense_en [*3])
      else $error("soft reset did not reopen pad sensing");
   a_oe_blank: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      oe_n_s |=> !led_out_en)
      else $error("LED outputs enabled while enable pin high");
   a_soft_pulse: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      soft_reset |=> !soft_reset && !led_out_en && !addr_valid)
      else $error("soft reset not a clean one-cycle reinit");
   a_ack_match: assert property (
      @(posedge scl_i) disable iff (!rst_n)
      (link_st_q == QAS_L_ADDR && bit_cnt_q == BITS_PER_BYTE && !own_match && !gc_write)
      |-> !sda_oe)
      else $error("acknowledge driven for a foreign address");
   a_ack_release: assert property (
      @(posedge scl_i) disable iff (!rst_n)
      sda_oe |=> !sda_oe)
      else $error("acknowledge held past its slot");

endmodule : qas_top

// [include/qas_pkg.sv]
// constants and types for the quinary address select block
package qas_pkg;

   // ****************************************************************
   // address and pad coding
   // ****************************************************************
   localparam int unsigned  ADDR_W       = 7;
   localparam int unsigned  BYTE_W       = 8;
   localparam int unsigned  PAD_W        = 3;
   localparam int unsigned  PAD_NUM      = 3;
   localparam int unsigned  PADS_W       = PAD_W * PAD_NUM;
   localparam logic [2:0]   PAD_GROUND   = 3'h0;
   localparam logic [2:0]   PAD_PULLDOWN = 3'h1;
   localparam logic [2:0]   PAD_FLOATING = 3'h2;
   localparam logic [2:0]   PAD_PULLUP   = 3'h3;
   localparam logic [2:0]   PAD_SUPPLY   = 3'h4;
   localparam logic [6:0]   WEIGHT_MSD   = 7'h19;
   localparam logic [6:0]   WEIGHT_MID   = 7'h05;
   localparam logic [6:0]   ADDR_OFFSET  = 7'h01;
   localparam logic [6:0]   ADDR_RESET   = 7'h00;

   // ****************************************************************
   // bus frame constants
   // ****************************************************************
   localparam logic [6:0]   GEN_CALL_ADDR = 7'h00;
   localparam logic [7:0]   SOFT_RST_BYTE = 8'h06;
   localparam logic [3:0]   BITS_PER_BYTE = 4'h8;
   localparam logic [3:0]   BIT_CNT_ZERO  = 4'h0;
   localparam logic [3:0]   BIT_CNT_ONE   = 4'h1;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int unsigned  CLK_PERIOD_NS = 100;
   localparam int unsigned  PAD_SETTLE_NS = 1000;
   localparam int unsigned  PAD_SETTLE_CYC =
      (PAD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
      (PAD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned  SETTLE_W = 8;

   // ****************************************************************
   // states
   // ****************************************************************
   typedef enum logic [1:0]
   {
      QAS_SENSE,
      QAS_RUN
   } qas_core_st_t;

   typedef enum logic [1:0]
   {
      QAS_L_IDLE,
      QAS_L_ADDR,
      QAS_L_DATA,
      QAS_L_SKIP
   } qas_link_st_t;

endpackage : qas_pkg

// [logic/qas_sync.sv]
// three-stage synchroniser with agreement filter on the last two stages
`timescale 1ns/1ps
module qas_sync
   import qas_pkg::*;
#(
   parameter int unsigned W   = 1,
   parameter logic [W-1:0] RST = '0
)
(
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // asynchronous input and filtered result
   input  wire logic [W-1:0]  d_async,
   output      logic [W-1:0]  q_sync
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;

   // first stage is read only by the second
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
      end
      else
      begin
         s1_q <= d_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a bit changes only once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               out_q[i] <= RST[i];
            else if (s2_q[i] == s3_q[i])
               out_q[i] <= s3_q[i];
         end
      end
   endgenerate

   assign q_sync = out_q;

endmodule : qas_sync

// [verification/qas_bus_ctl.sv]
// bus controller model that clocks frames into the device's link
`timescale 1ns/1ps
module qas_bus_ctl
(
   // resolved data wire, pulled up
   input  wire logic sda,
   // link clock and data pull-down
   output      logic scl,
   output      logic sda_pull
);
   // ****************************************************************
   // idle bus
   // ****************************************************************
   // clock stands high between frames, data released
   initial
   begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end

   // ****************************************************************
   // frame tasks
   // ****************************************************************
   // one 32 ns bit, data set well inside the low phase
   task automatic clk_bit(input logic b, output logic s);
   begin
      scl = 1'b0;
      #4 sda_pull = ~b;
      #12 scl = 1'b1;
      s = sda;
      #16;
   end
   endtask : clk_bit

   task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input int n, output logic [1:0] ack);
      logic s;
      int   i;
   begin
      ack = 2'b00;
      // idle pulses let the link domain see the latched address first
      for (i = 0; i < 3; i++)
         clk_bit(1'b1, s);
      sda_pull = 1'b1;
      #8;
      for (i = 0; i < 8 * n; i++)
      begin
         clk_bit(i < 8 ? b0[7 - i] : b1[15 - i], s);
         if (i % 8 == 7)
         begin
            clk_bit(1'b1, s);
            ack[i / 8] = ~s;
         end
      end
      // stop, then release the wire so it floats high
      scl = 1'b0;
      #4 sda_pull = 1'b1;
      #12 scl = 1'b1;
      #8 sda_pull = 1'b0;
   end
   endtask : frame

endmodule : qas_bus_ctl

// [verification/qas_top_tb.sv]
// self-checking bench for the quinary address select block
`timescale 1ns/1ps
module qas_top_tb
   import qas_pkg::*;
;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic              core_clk = 1'b0;
   logic              rst_n    = 1'b0;
   logic [PAD_W-1:0]  addr_pad_lsd = 3'h0;
   logic [PAD_W-1:0]  addr_pad_mid = 3'h0;
   logic [PAD_W-1:0]  addr_pad_msd = 3'h0;
   logic              oe_n = 1'b0;
   logic              scl;
   logic              sda_pull;
   logic              sda_w;
   logic              sda_o;
   logic              sda_oe;
   logic              pad_sense_en;
   logic [ADDR_W-1:0] target_addr;
   logic              addr_valid;
   logic              led_out_en;
   logic              addr_hit;
   logic              soft_reset;
   int                err_count = 0;
   int                compares  = 0;
   int                hit_cnt   = 0;
   int                soft_cnt  = 0;
   logic [1:0]        ack;

   // ****************************************************************
   // clock, wire and instances
   // ****************************************************************
   always #50 core_clk = ~core_clk;
   // open drain wire with pull-up: low if anyone pulls
   assign sda_w = ~(sda_pull | sda_oe);

   qas_top qas_top_i (.core_clk(core_clk), .rst_n(rst_n), .addr_pad_lsd(addr_pad_lsd),
      .addr_pad_mid(addr_pad_mid), .addr_pad_msd(addr_pad_msd), .oe_n(oe_n), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .pad_sense_en(pad_sense_en),
      .target_addr(target_addr), .addr_valid(addr_valid), .led_out_en(led_out_en),
      .addr_hit(addr_hit), .soft_reset(soft_reset));

   qas_bus_ctl qas_bus_ctl_i (.sda(sda_w), .scl(scl), .sda_pull(sda_pull));

   // one-cycle pulses are counted so no edge can be missed
   always @(posedge core_clk)
   begin
      if (addr_hit === 1'b1)
         hit_cnt++;
      if (soft_reset === 1'b1)
         soft_cnt++;
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
   begin
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR at %0t: expected %0h got %0h", $time, exp, got);
      end
   end
   endtask : chk

   task automatic end_sim;
   begin
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask : end_sim

   task automatic do_reset(input logic [2:0] m, input logic [2:0] d, input logic [2:0] l);
   begin
      @(posedge core_clk);
      #5;
      rst_n = 1'b0;
      addr_pad_msd = m;
      addr_pad_mid = d;
      addr_pad_lsd = l;
      @(posedge core_clk);
      #5;
      chk(8'h01, {7'h00, pad_sense_en});
      chk(8'h00, {1'b0, target_addr});
      chk(8'h00, {7'h00, led_out_en});
      rst_n = 1'b1;
   end
   endtask : do_reset

   // bounded wait until sensing switches off or back on
   task automatic wait_sense(input logic lvl);
      int i;
   begin
      for (i = 0; i < 40 && pad_sense_en !== lvl; i++)
         @(posedge core_clk);
      #5;
      chk({7'h00, lvl}, {7'h00, pad_sense_en});
   end
   endtask : wait_sense

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_addr_table;
      int m;
      int d;
      int l;
   begin
      for (m = 0; m < 5; m++)
         for (d = 0; d < 5; d++)
            for (l = 0; l < 5; l++)
            begin
               do_reset(m[2:0], d[2:0], l[2:0]);
               wait_sense(1'b0);
               chk(8'(25 * m + 5 * d + l + 1), {1'b0, target_addr});
               chk(8'h01, {7'h00, addr_valid});
            end
      $display("test addr_table done");
   end
   endtask : t_addr_table

   task automatic t_frames;
      int h;
   begin
      do_reset(3'h0, 3'h1, 3'h0);
      wait_sense(1'b0);
      h = hit_cnt;
      qas_bus_ctl_i.frame(8'h0C, 8'h00, 1, ack);
      chk(8'h01, {6'h00, ack});
      chk(8'h00, {7'h00, sda_o});
      repeat (10) @(posedge core_clk);
      chk(8'h01, 8'(hit_cnt - h));
      qas_bus_ctl_i.frame(8'h0D, 8'h00, 1, ack);
      chk(8'h00, {6'h00, ack});
      qas_bus_ctl_i.frame(8'h0E, 8'h00, 1, ack);
      chk(8'h00, {6'h00, ack});
      repeat (10) @(posedge core_clk);
      chk(8'h01, 8'(hit_cnt - h));
      $display("test frames done");
   end
   endtask : t_frames

   task automatic t_soft_reset;
      int s;
   begin
      @(posedge core_clk);
      #5;
      addr_pad_msd = 3'h4;
      addr_pad_mid = 3'h4;
      addr_pad_lsd = 3'h4;
      repeat (20) @(posedge core_clk);
      #5;
      chk(8'h06, {1'b0, target_addr});
      s = soft_cnt;
      qas_bus_ctl_i.frame(8'h00, 8'h05, 2, ack);
      repeat (10) @(posedge core_clk);
      chk(8'h01, {6'h00, ack});
      chk(8'h00, 8'(soft_cnt - s));
      qas_bus_ctl_i.frame(8'h00, SOFT_RST_BYTE, 2, ack);
      chk(8'h03, {6'h00, ack});
      wait_sense(1'b1);
      chk(8'h01, 8'(soft_cnt - s));
      wait_sense(1'b0);
      chk(8'h7D, {1'b0, target_addr});
      qas_bus_ctl_i.frame(8'hFA, 8'h00, 1, ack);
      chk(8'h01, {6'h00, ack});
      $display("test soft_reset done");
   end
   endtask : t_soft_reset

   task automatic t_oe;
   begin
      chk(8'h01, {7'h00, led_out_en});
      @(posedge core_clk);
      #5;
      oe_n = 1'b1;
      repeat (6) @(posedge core_clk);
      #5;
      chk(8'h00, {7'h00, led_out_en});
      oe_n = 1'b0;
      repeat (6) @(posedge core_clk);
      #5;
      chk(8'h01, {7'h00, led_out_en});
      $display("test oe done");
   end
   endtask : t_oe

   task automatic t_illegal;
   begin
      do_reset(3'h0, 3'h0, 3'h5);
      wait_sense(1'b0);
      chk(8'h00, {7'h00, addr_valid});
      qas_bus_ctl_i.frame(8'h0C, 8'h00, 1, ack);
      chk(8'h00, {6'h00, ack});
      $display("test illegal done");
   end
   endtask : t_illegal

   // ****************************************************************
   // main sequence and watchdog
   // ****************************************************************
   initial
   begin
      repeat (10) @(posedge core_clk);
      #5;
      rst_n = 1'b1;
      t_addr_table();
      t_frames();
      t_soft_reset();
      t_oe();
      t_illegal();
      end_sim();
   end

   // the tests need well under half a millisecond
   initial
   begin
      #1000000;
      err_count++;
      end_sim();
   end

endmodule : qas_top_tb
